// file: verilog/sar_pkg.sv
package sar_pkg;

	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------

	// Result width after elaboration; 8 and 12 are the built variants.
	localparam int RESULT_WIDTH_DEFAULT = 8;
	localparam int RESULT_WIDTH_WIDE    = 12;

	// System clock and the bit rate of the approximation loop.
	localparam int CLK_SYS_HZ = 10_000_000;
	localparam int BIT_HZ     = 5_000_000;

	// System clocks per bit step, rounded down so the step is never slower than asked.
	localparam int BIT_DIV_CYCLES = (CLK_SYS_HZ / BIT_HZ) < 1 ? 1 : (CLK_SYS_HZ / BIT_HZ);

	// Depth of the result FIFO in words.
	localparam int RESULT_FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------

	localparam logic DONE_N_RESET = 1'b1;
	localparam logic ECHO_RESET   = 1'b0;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b10
	} sar_state_t;

endpackage : sar_pkg

// file: verilog/result_fifo.sv
`timescale 1ns/1ps

module result_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             srst,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	wire              do_push;
	wire              do_pop;

	// ----------------------------------------------------------------
	// Handshakes
	// ----------------------------------------------------------------

	// A word moves on each side only when both valid and ready are high.
	assign do_push   = in_valid && in_ready;
	assign do_pop    = out_valid && out_ready;
	assign in_ready  = (fill != (AW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign out_data  = mem[rd_ptr];

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------

	// Pointers wrap at the depth so any depth works, not only powers of two.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (do_push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			fill <= fill + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

endmodule : result_fifo

// file: verilog/successive_approx_register.sv
`timescale 1ns/1ps
// How it works
// - Result register built eight or twelve bits wide.
// - Control latched separately; result updates on step edge.
// - Each step captures comparator into trial bit.
// - Same step drives next lower bit low.
// - Start low resets: top low, others high.
// - Start reset raises conversion done flag high.
// - First step loads top bit, then downward.
// - Bit zero loaded: done low, result frozen; serial echo still follows each step.
// - Inverted top result bit offered separately.
// - Enable high forces top high, blocks data.
// - Serial echo is input delayed one bit.
// - Done flag high throughout conversion, low after.

module successive_approx_register
#(
	parameter int WIDTH      = sar_pkg::RESULT_WIDTH_DEFAULT,
	parameter int BIT_DIV    = sar_pkg::BIT_DIV_CYCLES,
	parameter int FIFO_DEPTH = sar_pkg::RESULT_FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             srst,
	// Loop pins from controller, comparator and neighbour.
	input  wire logic             start_n,
	input  wire logic             data_in,
	input  wire logic             enable_n,
	// Parallel result towards the D/A converter, plus serial echo and done flag.
	output logic      [WIDTH-1:0] result,
	output logic                  top_result_bit_n,
	output logic                  serial_echo,
	output logic                  conversion_done_n,
	// Finished words, buffered.
	output logic                  word_valid,
	input  wire logic             word_ready,
	output logic      [WIDTH-1:0] word_data
);
	import sar_pkg::*;

	localparam int IW = (WIDTH > 1) ? $clog2(WIDTH) : 1;
	localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

	// Synchroniser stages; the first stage of each is read only by the second.
	logic [1:0] start_sync;
	logic [1:0] data_sync;
	logic [1:0] enable_sync;
	wire        start_s;
	wire        data_s;
	wire        enable_s;

	logic [DW-1:0]    div_cnt;
	logic             step;
	logic             enable_step;
	sar_state_t       state;
	sar_state_t       next_state;
	logic [WIDTH-1:0] sar;
	logic [WIDTH-1:0] next_sar;
	logic [IW-1:0]    trial_idx;
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             fifo_out_valid;
	logic [WIDTH-1:0] fifo_out_data;
	wire              at_last_bit;
	wire              accept;
	wire              restart;
	wire              top_forced;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	// Every loop pin comes from outside this clock and passes two flops.
	always_ff @(posedge clk_sys) begin
		start_sync  <= {start_sync[0], start_n};
		data_sync   <= {data_sync[0], data_in};
		enable_sync <= {enable_sync[0], enable_n};
	end

	assign start_s  = start_sync[1];
	assign data_s   = data_sync[1];
	assign enable_s = enable_sync[1];

	// ----------------------------------------------------------------
	// Bit rate divider
	// ----------------------------------------------------------------

	// One-cycle step pulse stands in for the rising edge of the bit clock.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			div_cnt <= '0;
			step    <= 1'b0;
		end else begin
			step    <= (div_cnt == DW'(BIT_DIV - 1));
			div_cnt <= (div_cnt == DW'(BIT_DIV - 1)) ? '0 : div_cnt + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencing decisions
	// ----------------------------------------------------------------

	// Control decisions are formed between steps and only take effect on a step.
	assign restart     = step && !start_s;
	assign at_last_bit = (trial_idx == '0);
	// The final bit waits for FIFO room, so a stalled reader stalls the loop.
	assign accept      = step && start_s && (state == ST_CONV) && !enable_s && !enable_step
	                     && (!at_last_bit || push_ready);
	assign top_forced  = enable_s;

	// ----------------------------------------------------------------
	// Enable tracking
	// ----------------------------------------------------------------

	// Enable as it stood at the last step; a release only counts from the next step,
	// so the comparator has a whole bit period to answer for the freed top bit.
	always_ff @(posedge clk_sys) begin
		if (srst)
			enable_step <= 1'b1;
		else if (step)
			enable_step <= enable_s;
	end

	// Next register contents and state.
	always_comb begin
		next_sar   = sar;
		next_state = state;
		if (restart) begin
			next_sar            = '1;
			next_sar[WIDTH-1]   = 1'b0;
			next_state          = ST_CONV;
		end else if (accept) begin
			next_sar[trial_idx] = data_s;
			if (!at_last_bit)
				next_sar[trial_idx - 1'b1] = 1'b0;
			else
				next_state = ST_DONE;
		end
	end

	// ----------------------------------------------------------------
	// Result and control registers
	// ----------------------------------------------------------------

	// Result data moves only on a step; DONE holds everything until a restart.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state     <= ST_IDLE;
			sar       <= '0;
			trial_idx <= IW'(WIDTH - 1);
		end else begin
			state <= next_state;
			sar   <= next_sar;
			if (restart)
				trial_idx <= IW'(WIDTH - 1);
			else if (accept && !at_last_bit)
				trial_idx <= trial_idx - 1'b1;
		end
	end

	// Done flag: high from the start reset until bit zero is in.
	always_ff @(posedge clk_sys) begin
		if (srst)
			conversion_done_n <= DONE_N_RESET;
		else if (restart)
			conversion_done_n <= 1'b1;
		else if (accept && at_last_bit)
			conversion_done_n <= 1'b0;
	end

	// Outputs come from flops; a high enable overrides the top bit.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			result           <= '0;
			top_result_bit_n <= 1'b1;
		end else begin
			result           <= {next_sar[WIDTH-1] | top_forced, next_sar[WIDTH-2:0]};
			top_result_bit_n <= ~(next_sar[WIDTH-1] | top_forced);
		end
	end

	// Serial echo repeats the comparator one bit period later.
	always_ff @(posedge clk_sys) begin
		if (srst)
			serial_echo <= ECHO_RESET;
		else if (step)
			serial_echo <= data_s;
	end

	// ----------------------------------------------------------------
	// Result buffering
	// ----------------------------------------------------------------

	// The finished word enters the FIFO on the step that loads bit zero.
	assign push_valid = accept && at_last_bit;
	assign push_data  = next_sar;

	result_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (fifo_out_valid),
		.out_ready (word_ready && word_valid),
		.out_data  (fifo_out_data)
	);

	// Output stage of the buffer: registered valid and data, one word deep.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			word_valid <= 1'b0;
			word_data  <= '0;
		end else if (!word_valid || word_ready) begin
			word_valid <= fifo_out_valid && !(word_valid && word_ready);
			word_data  <= fifo_out_data;
		end
	end

endmodule : successive_approx_register

// file: tb/sar_checker.sv
`timescale 1ns/1ps
// Watches the register's pins and its buffered result stream.
module sar_checker #(
	parameter int WIDTH   = 8,
	parameter int BIT_DIV = 2
) (
	input wire logic             clk_sys,
	input wire logic             srst,
	input wire logic             start_n,
	input wire logic             data_in,
	input wire logic             enable_n,
	input wire logic [WIDTH-1:0] result,
	input wire logic             top_result_bit_n,
	input wire logic             serial_echo,
	input wire logic             conversion_done_n,
	input wire logic             word_valid,
	input wire logic             word_ready,
	input wire logic [WIDTH-1:0] word_data
);
	logic [2:0] en_lo;
	logic [2:0] en_hi;
	// Cycles that enable has stood low or high, saturating at seven.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			en_lo <= 3'h0;
			en_hi <= 3'h0;
		end else begin
			en_lo <= enable_n ? 3'h0 : (en_lo == 3'h7 ? en_lo : en_lo + 3'h1);
			en_hi <= !enable_n ? 3'h0 : (en_hi == 3'h7 ? en_hi : en_hi + 3'h1);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_sync_reset: assert property (disable iff (1'b0) srst |=> conversion_done_n && !word_valid)
		else $error("reset did not clear done and valid");
	a_start_value: assert property ($rose(conversion_done_n) && en_lo == 3'h7 |->
		result == {1'b0, {(WIDTH-1){1'b1}}}) else $error("restart value wrong");
	a_done_span: assert property ($fell(conversion_done_n) |-> $past(conversion_done_n, WIDTH*BIT_DIV))
		else $error("conversion ended too early");
	a_result_frozen: assert property (!conversion_done_n && !$past(conversion_done_n) && en_lo == 3'h7
		|-> $stable(result)) else $error("result moved after completion");
	a_top_complement: assert property (top_result_bit_n == !result[WIDTH-1])
		else $error("complement output wrong");
	a_enable_top: assert property (en_hi == 3'h7 |-> result[WIDTH-1])
		else $error("top bit not forced high");
	a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("word dropped before taken");
	a_word_pushed: assert property ($fell(conversion_done_n) |-> ##[1:4] word_valid)
		else $error("finished word not offered");
endmodule : sar_checker

// file: tb/sar_loop_model.sv
`timescale 1ns/1ps
// Comparator behind the D/A converter: answers with the target bit under trial.
module sar_loop_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] result,
	input  wire logic [7:0] target,
	input  wire logic       slow,
	output logic            data_in
);
	logic [7:0] trial;
	logic       cmp;
	logic [1:0] lag;
	logic       flip = 1'b0;
	// The lowest cleared bit is under trial; with none, the output wanders.
	assign trial   = ~result & (result + 8'h01);
	assign cmp     = (trial == 8'h00) ? flip : |(trial & target);
	assign data_in = slow ? lag[1] : cmp;
	// A slow comparator settles two cycles late.
	always_ff @(posedge clk_sys) begin
		flip <= !flip;
		lag  <= {lag[0], cmp};
	end
endmodule : sar_loop_model

// file: tb/tb_successive_approx_register.sv
`timescale 1ns/1ps
module tb_successive_approx_register;
	localparam int W  = 8;
	localparam int BD = 8;
	logic         clk_sys = 1'b0, srst = 1'b1, start_n = 1'b1, enable_n = 1'b0;
	logic         word_ready = 1'b0, slow = 1'b0, ok;
	logic         data_in, top_result_bit_n, serial_echo, conversion_done_n, word_valid;
	logic [W-1:0] result, word_data, v;
	logic [W-1:0] tgt = 8'h00;
	logic [W-1:0] corner[4] = '{8'h00, 8'hff, 8'h80, 8'h01};
	logic [W-1:0] held[$];
	int           err_count = 0;
	int           comparisons = 0;
	int           n = 0;
	// Free-running system clock.
	always #50 clk_sys = !clk_sys;
	successive_approx_register #(.WIDTH(W), .BIT_DIV(BD), .FIFO_DEPTH(8)) i_dut (.clk_sys(clk_sys),
		.srst(srst), .start_n(start_n), .data_in(data_in), .enable_n(enable_n), .result(result),
		.top_result_bit_n(top_result_bit_n), .serial_echo(serial_echo), .conversion_done_n(conversion_done_n),
		.word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
	sar_loop_model i_loop (.clk_sys(clk_sys), .result(result), .target(tgt), .slow(slow), .data_in(data_in));
	task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	// Waits a bounded time for the done flag; running out ends the run.
	task automatic wait_done(input logic lvl, input int lim);
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			@(negedge clk_sys);
			ok = (conversion_done_n === lvl);
		end
		if (!ok) begin
			err_count++;
			report_and_stop();
		end
	endtask : wait_done
	task automatic start(input logic [W-1:0] t, input logic hold_en);
		@(posedge clk_sys);
		tgt      <= t;
		start_n  <= 1'b0;
		enable_n <= hold_en;
		slow     <= 1'($urandom);
		repeat (3 * BD) @(posedge clk_sys);
		start_n <= 1'b1;
		wait_done(1'b1, 4 * BD);
	endtask : start
	task automatic finish(input logic [W-1:0] t);
		wait_done(1'b0, 16 * BD);
		check("result", result, t);
	endtask : finish
	task automatic pop(input logic [W-1:0] exp);
		@(negedge clk_sys);
		for (int i = 0; i < 8 && word_valid !== 1'b1; i++) @(negedge clk_sys);
		check("valid", {7'h00, word_valid}, 8'h01);
		check("word", word_data, exp);
		@(posedge clk_sys);
		word_ready <= 1'b1;
		@(posedge clk_sys);
		word_ready <= 1'b0;
	endtask : pop
	initial begin
		void'($urandom(19743));
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		// Corner codes, then random ones, each held and read back.
		for (int i = 0; i < 10; i++) begin
			v = (i < 4) ? corner[i] : W'($urandom);
			start(v, 1'b0);
			// Bit four turning low marks the top three bits as final.
			for (int j = 0; j < 8 * BD && result[4] !== 1'b0; j++) @(negedge clk_sys);
			check("trunc", {4'h0, result[7:4]}, {4'h0, v[7:5], 1'b0});
			finish(v);
			check("echo", {7'h00, serial_echo}, {7'h00, v[0]});
			check("top_n", {7'h00, top_result_bit_n}, {7'h00, ~v[7]});
			repeat (2 * BD) @(negedge clk_sys);
			check("frozen", result, v);
			pop(v);
		end
		// Enable held high keeps the top bit high and blocks the data.
		start(8'h5a, 1'b1);
		repeat (10 * BD) @(negedge clk_sys);
		check("busy", {7'h00, conversion_done_n}, 8'h01);
		check("top", {7'h00, result[7]}, 8'h01);
		@(posedge clk_sys);
		enable_n <= 1'b0;
		finish(8'h5a);
		pop(8'h5a);
		// Continuous mode: done feeds start until two more words are made.
		v = W'($urandom);
		tgt <= v;
		n = 0;
		for (int i = 0; i < 40 * BD && n < 3; i++) begin
			@(posedge clk_sys);
			if (conversion_done_n === 1'b0 && start_n) n++;
			if (n < 3) start_n <= conversion_done_n;
		end
		check("rounds", W'(n), 8'h03);
		finish(v);
		pop(v);
		pop(v);
		// Eight words fill the buffer; the ninth conversion has to wait.
		for (int i = 0; i < 9; i++) begin
			v = W'($urandom);
			held.push_back(v);
			start(v, 1'b0);
			if (i < 8) finish(v);
		end
		repeat (20 * BD) @(negedge clk_sys);
		check("stalled", {7'h00, conversion_done_n}, 8'h01);
		for (int i = 0; i < 8; i++) pop(held.pop_front());
		finish(held[0]);
		pop(held.pop_front());
		report_and_stop();
	end
endmodule : tb_successive_approx_register
bind successive_approx_register sar_checker #(.WIDTH(WIDTH), .BIT_DIV(BIT_DIV)) i_chk (.clk_sys(clk_sys),
	.srst(srst), .start_n(start_n), .data_in(data_in), .enable_n(enable_n), .result(result),
	.top_result_bit_n(top_result_bit_n), .serial_echo(serial_echo), .conversion_done_n(conversion_done_n),
	.word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
